/* File: dv/fcso_fan_model.sv */
// Purpose: fan fed by one duty code
// Assumes: any nonzero duty spins the fan
// Notes: reports spin and full speed one clock after the duty
`timescale 1ns/1ps
`default_nettype none
module fcso_fan_model (
  input wire logic clock, // system clock
  input wire logic [7:0] duty, // duty code from the controller
  output logic spinning, // fan turning
  output logic full_speed // fan at full duty
);
  always_ff @(posedge clock) begin
    spinning <= duty != 8'h00;
    full_speed <= duty == 8'hff;
  end
endmodule // fcso_fan_model
`default_nettype wire

/* File: dv/fcso_top_assertions.sv */
// Purpose: port-level checks of fan duty, critical override and read port
// Assumes: duty outputs lag their inputs by two clocks
// Notes: register contents are not visible here, only their effects
`timescale 1ns/1ps
`default_nettype none
module fcso_top_assertions (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic reg_rd_en, // read strobe
  input wire logic reg_wr_en, // write strobe
  input wire logic [7:0] temp_local, // local temperature
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_rd_data, // read data
  input wire logic [7:0] min_duty_one, // output one minimum
  input wire logic [7:0] max_duty_one, // output one maximum
  input wire logic [7:0] fan_output_one, // output one duty
  input wire logic [7:0] fan_output_two, // output two duty
  input wire logic [7:0] fan_output_three, // output three duty
  input wire logic [2:0] fan_running, // per-output on state
  input wire logic [2:0] critical_chan_status, // per-channel override
  input wire logic critical_temp_signal // override to all fans
);
  logic mapped;
  assign mapped = (reg_addr >= 8'h5f && reg_addr <= 8'h62) || (reg_addr >= 8'h6a && reg_addr <= 8'h6e);

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_bad_rd;
    reg_rd_en && !mapped;
  endsequence
  sequence s_all_full;
    fan_output_one == 8'hff && fan_output_two == 8'hff && fan_output_three == 8'hff;
  endsequence

  property p_crit_full;
    critical_temp_signal |-> s_all_full;
  endproperty
  a_crit_full: assert property (p_crit_full) else $error("override without full duty");
  property p_crit_or;
    critical_temp_signal == (|critical_chan_status);
  endproperty
  a_crit_or: assert property (p_crit_or) else $error("override not the or of channels");
  // local override may not drop while its temperature holds or rises and no register changed
  property p_release;
    critical_chan_status[1] && $past(temp_local) >= $past(temp_local, 2) && !$past(reg_wr_en, 2)
      |=> critical_chan_status[1];
  endproperty
  a_release: assert property (p_release) else $error("override released on steady temperature");
  property p_off_zero;
    !fan_running[0] && !critical_temp_signal |-> fan_output_one == 8'h00;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("stopped fan has nonzero duty");
  property p_max_clamp;
    !critical_temp_signal |-> fan_output_one <= $past(max_duty_one, 2);
  endproperty
  a_max_clamp: assert property (p_max_clamp) else $error("duty above maximum");
  property p_min_floor;
    fan_running[0] && !critical_temp_signal && $past(min_duty_one, 2) <= $past(max_duty_one, 2)
      |-> fan_output_one >= $past(min_duty_one, 2);
  endproperty
  a_min_floor: assert property (p_min_floor) else $error("running duty below minimum");
  property p_unmapped_rd;
    s_bad_rd |=> reg_rd_data == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_rd_hold;
    !reg_rd_en |=> $stable(reg_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
endmodule // fcso_top_assertions
`default_nettype wire

/* File: dv/fcso_top_tb_top.sv */
// Purpose: register and fan duty tests of the slope and override block
// Assumes: two clock latency from inputs to duty outputs
// Notes: slope test expectations come from the slope table held here; the other tests check literal values
`timescale 1ns/1ps
`default_nettype none
module fcso_top_tb_top;
  logic clock = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, spin, full;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, o1, o2, o3;
  logic [7:0] t1 = 8'h30, tl = 8'h30, t2 = 8'h30, mn = 8'h55, mx = 8'hff;
  logic [1:0] s1 = 2'h0, s2 = 2'h1, s3 = 2'h2;
  logic [2:0] run, cst;
  logic csig;
  int fail_count = 0, samples_checked = 0;
  logic [7:0] adr [9] = '{8'h5f, 8'h60, 8'h61, 8'h62, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e};
  logic [7:0] rsv [9] = '{8'hc0, 8'hc0, 8'hc0, 8'h00, 8'ha4, 8'ha4, 8'ha4, 8'h44, 8'h40};
  int sl [16] = '{1360, 1088, 816, 680, 544, 408, 340, 272, 204, 170, 136, 102, 85, 68, 51, 34};

  always #2.5 clock = ~clock;

  fcso_top fcso_top_inst (.clock(clock), .sys_rst(sys_rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wr_data(wdat), .reg_rd_data(rdat), .temp_remote_one(t1), .temp_local(tl),
    .temp_remote_two(t2), .fan_start_temp_remote_one(8'h50), .fan_start_temp_local(8'h50),
    .fan_start_temp_remote_two(8'h50), .min_duty_one(mn), .min_duty_two(mn), .min_duty_three(mn),
    .max_duty_one(mx), .max_duty_two(mx), .max_duty_three(mx), .fan_chan_sel_one(s1),
    .fan_chan_sel_two(s2), .fan_chan_sel_three(s3), .fan_output_one(o1), .fan_output_two(o2),
    .fan_output_three(o3), .fan_running(run), .critical_chan_status(cst), .critical_temp_signal(csig));
  fcso_fan_model fcso_fan_model_inst (.clock(clock), .duty(o2), .spinning(spin), .full_speed(full));

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1; addr <= a; wdat <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    rd_en <= 1'b1; addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
    #1 cmp8(rdat, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic chk3(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
    cmp8(o1, e1);
    cmp8(o2, e2);
    cmp8(o3, e3);
  endtask
  function automatic logic [7:0] ramp(input int code, input int m, input int d);
    int v;
    v = m + ((d * sl[code]) >> 4);
    return (v > 255) ? 8'hff : v[7:0];
  endfunction
  task automatic slope(input int code, input logic [7:0] m, input int d);
    wr(8'h5f, {code[3:0], 4'h0});
    @(posedge clock);
    mn <= m; t1 <= 8'h50 + d[7:0];
    settle();
    cmp8(o1, ramp(code, m, d));
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(adr[i], rsv[i]);
    rd(8'h63, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 9; i++) begin
      wr(adr[i], ~rsv[i]);
      rd(adr[i], ~rsv[i]);
      wr(adr[i], rsv[i]);
    end
    $display("test readback done");
    for (int c = 0; c < 16; c++) slope(c, 8'h55, 10);
    slope(13, 8'h55, 39);
    slope(13, 8'h55, 40);
    slope(13, 8'h80, 29);
    slope(13, 8'h80, 30);
    $display("test slope done");
    @(posedge clock);
    mn <= 8'h55; t1 <= 8'h30; s1 <= 2'h1; s3 <= 2'h1; tl <= 8'h51;
    wr(8'h60, 8'hc0);
    settle();
    chk3(8'h5a, 8'h5a, 8'h5a);
    @(posedge clock);
    tl <= 8'h50;
    settle();
    chk3(8'h55, 8'h55, 8'h55);
    @(posedge clock);
    tl <= 8'h4c;
    settle();
    chk3(8'h55, 8'h55, 8'h55);
    @(posedge clock);
    tl <= 8'h4b;
    settle();
    chk3(8'h00, 8'h00, 8'h00);
    cmp8({5'h0, run}, 8'h00);
    cmp8({7'h0, spin}, 8'h00);
    wr(8'h62, 8'he0);
    settle();
    chk3(8'h55, 8'h55, 8'h55);
    cmp8({5'h0, run}, 8'h07);
    cmp8({7'h0, spin}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(8'h62, 8'h20 << i);
      settle();
      chk3(i == 0 ? 8'h55 : 8'h00, i == 1 ? 8'h55 : 8'h00, i == 2 ? 8'h55 : 8'h00);
    end
    $display("test fan_hold done");
    wr(8'h62, 8'h00);
    wr(8'h6d, 8'h42); // local hysteresis 2, never zero
    @(posedge clock);
    mx <= 8'h60; tl <= 8'ha5;
    settle();
    chk3(8'hff, 8'hff, 8'hff);
    cmp8({5'h0, cst}, 8'h02);
    cmp8({7'h0, full}, 8'h01);
    @(posedge clock);
    tl <= 8'ha2;
    settle();
    chk3(8'hff, 8'hff, 8'hff);
    @(posedge clock);
    tl <= 8'ha1;
    settle();
    chk3(8'h60, 8'h60, 8'h60);
    cmp8({7'h0, csig}, 8'h00);
    wr(8'h6c, 8'h40);
    @(posedge clock);
    t2 <= 8'h41;
    settle();
    cmp8({5'h0, cst}, 8'h04);
    @(posedge clock);
    t2 <= 8'h3c;
    settle();
    cmp8({5'h0, cst}, 8'h04);
    @(posedge clock);
    t2 <= 8'h3b;
    settle();
    cmp8({5'h0, cst}, 8'h00);
    @(posedge clock);
    s1 <= 2'h3; s3 <= 2'h2;
    settle();
    chk3(8'h00, 8'h60, 8'h00);
    $display("test critical done");
    conclude();
  end
endmodule // fcso_top_tb_top

bind fcso_top fcso_top_assertions fcso_top_assertions_inst (.clock(clock), .sys_rst(sys_rst),
  .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .temp_local(temp_local),
  .reg_addr(reg_addr), .reg_rd_data(reg_rd_data), .min_duty_one(min_duty_one),
  .max_duty_one(max_duty_one), .fan_output_one(fan_output_one), .fan_output_two(fan_output_two),
  .fan_output_three(fan_output_three), .fan_running(fan_running),
  .critical_chan_status(critical_chan_status), .critical_temp_signal(critical_temp_signal));
`default_nettype wire

/* File: pkg/fcso_pkg.sv */
// Purpose: shared constants for fan slope and critical temperature override
// Assumes: 8-bit temperature codes in one encoding for readings, limits and start points
// Notes: slope table gives duty codes per degree, scaled by 16
package fcso_pkg;

  localparam int unsigned fcso_chan_n = 3;
  localparam int unsigned fcso_out_n = 3;

  // register offsets
  localparam logic [7:0] fcso_off_slope_r1 = 8'h5f;
  localparam logic [7:0] fcso_off_slope_loc = 8'h60;
  localparam logic [7:0] fcso_off_slope_r2 = 8'h61;
  localparam logic [7:0] fcso_off_hold = 8'h62;
  localparam logic [7:0] fcso_off_crit_r1 = 8'h6a;
  localparam logic [7:0] fcso_off_crit_loc = 8'h6b;
  localparam logic [7:0] fcso_off_crit_r2 = 8'h6c;
  localparam logic [7:0] fcso_off_hyst_a = 8'h6d;
  localparam logic [7:0] fcso_off_hyst_b = 8'h6e;

  // reset values
  localparam logic [7:0] fcso_rst_slope = 8'hc0;
  localparam logic [7:0] fcso_rst_hold = 8'h00;
  localparam logic [7:0] fcso_rst_crit = 8'ha4;
  localparam logic [7:0] fcso_rst_hyst_a = 8'h44;
  localparam logic [7:0] fcso_rst_hyst_b = 8'h40;

  // field positions
  localparam int unsigned fcso_slope_lsb = 4;
  localparam int unsigned fcso_hyst_hi_lsb = 4;
  localparam int unsigned fcso_hyst_lo_lsb = 0;
  localparam int unsigned fcso_hold_lsb = 5;

  // duty codes
  localparam logic [7:0] fcso_duty_full = 8'hff;
  localparam logic [7:0] fcso_duty_off = 8'h00;
  localparam int unsigned fcso_slope_frac = 4;

  // channel select codes
  localparam logic [1:0] fcso_sel_r1 = 2'h0;
  localparam logic [1:0] fcso_sel_loc = 2'h1;
  localparam logic [1:0] fcso_sel_r2 = 2'h2;

  // 170 duty codes across the range, in codes per degree times 16
  function automatic logic [10:0] fcso_slope16(input logic [3:0] code);
    logic [10:0] s;
    s = 11'h000;
    case (code)
      4'h0: s = 11'd1360;
      4'h1: s = 11'd1088;
      4'h2: s = 11'd816;
      4'h3: s = 11'd680;
      4'h4: s = 11'd544;
      4'h5: s = 11'd408;
      4'h6: s = 11'd340;
      4'h7: s = 11'd272;
      4'h8: s = 11'd204;
      4'h9: s = 11'd170;
      4'ha: s = 11'd136;
      4'hb: s = 11'd102;
      4'hc: s = 11'd85;
      4'hd: s = 11'd68;
      4'he: s = 11'd51;
      default: s = 11'd34;
    endcase
    return s;
  endfunction

endpackage

/* File: src/fcso_crit.sv */
// Purpose: one channel's critical temperature detector with release hysteresis
// Assumes: temperature and limit share one encoding
// Notes: zero hysteresis releases as soon as the reading drops below the limit
`timescale 1ns/1ps
`default_nettype none
module fcso_crit (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic [7:0] temp, // measured temperature
  input wire logic [7:0] limit, // critical temperature limit
  input wire logic [3:0] hyst, // release hysteresis
  output logic active // override request, registered
);

  logic active_ff;
  logic nxt_active;
  wire logic [7:0] hyst_ext = {4'h0, hyst};
  wire logic [7:0] release_thr = (limit > hyst_ext) ? (limit - hyst_ext) : 8'h00;
  wire logic over = temp > limit;
  wire logic under = temp < release_thr;

  // set on exceeding, clear only below limit minus hysteresis
  assign nxt_active = over ? 1'b1 : (under ? 1'b0 : active_ff);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active;
    end
  end

  assign active = active_ff;

endmodule // fcso_crit
`default_nettype wire

/* File: src/fcso_fan.sv */
// Purpose: one fan output's automatic duty from its temperature channel
// Assumes: start temperature, min and max duty come from outside
// Notes: a minimum above the maximum yields the maximum
`timescale 1ns/1ps
`default_nettype none
module fcso_fan (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic [7:0] temp, // selected channel temperature
  input wire logic [7:0] start_temp, // fan start temperature
  input wire logic [3:0] hyst, // switch-off hysteresis
  input wire logic [3:0] slope_code, // range code
  input wire logic [7:0] min_duty, // minimum duty code
  input wire logic [7:0] max_duty, // maximum duty code
  input wire logic hold_min, // keep minimum duty below start
  output logic [7:0] duty, // automatic duty, registered
  output logic running // fan on state, registered
);

  logic run_ff;
  logic nxt_run;
  logic [7:0] duty_ff;
  logic [7:0] nxt_duty;

  wire logic [7:0] hyst_ext = {4'h0, hyst};
  wire logic [7:0] off_thr = (start_temp > hyst_ext) ? (start_temp - hyst_ext) : 8'h00;
  wire logic above = temp > start_temp;
  wire logic below_off = temp < off_thr;
  wire logic [7:0] delta = above ? (temp - start_temp) : 8'h00;
  wire logic [10:0] slope16 = fcso_pkg::fcso_slope16(slope_code);
  // fixed slope from min duty, full duty at start + (255-min)*range/170
  wire logic [18:0] prod = 19'(delta * slope16);
  wire logic [14:0] inc = prod[18:fcso_pkg::fcso_slope_frac];
  wire logic [15:0] sum = 16'(min_duty) + 16'(inc);
  wire logic [7:0] ramp = (sum > 16'(fcso_pkg::fcso_duty_full)) ? fcso_pkg::fcso_duty_full : sum[7:0];
  wire logic [7:0] clamped = (ramp > max_duty) ? max_duty : ramp;

  // off only after falling hysteresis below start; hold keeps it on
  assign nxt_run = hold_min ? 1'b1 : (above ? 1'b1 : (below_off ? 1'b0 : run_ff));
  // starts at min duty above start, held at min below it when running
  assign nxt_duty = nxt_run ? clamped : fcso_pkg::fcso_duty_off;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_ff <= 1'b0;
      duty_ff <= 8'h00;
    end else begin
      run_ff <= nxt_run;
      duty_ff <= nxt_duty;
    end
  end

  assign duty = duty_ff;
  assign running = run_ff;

endmodule // fcso_fan
`default_nettype wire

/* File: src/fcso_top.sv */
// Purpose: fan slope control and nonmaskable critical temperature override
// Assumes: register port driven by the serial host logic, one access per cycle
// Notes: duty outputs lag a temperature change by two clocks
// Contract
// - each channel keeps its own slope code in bits 7:4 of its register
// - codes 0..15 map to ranges 2 to 80 degrees, default code 1100
// - slope registers 0x5f remote one, 0x60 local, 0x61 remote two
// - with 33 percent minimum, full duty at start plus range
// - slope fixed; full duty at start plus (255-min)*range/170
// - any channel above its critical limit forces every fan to full duty
// - full duty holds until temperature falls below limit minus hysteresis
// - critical override cannot be masked by any fan control setting
// - critical limits at 0x6a, 0x6b, 0x6c, each resetting to 0xa4
// - hysteresis fields in 0x6d high/low and 0x6e high, default 4
// - four-bit hysteresis 1 to 15 degrees, zero disables it
// - below start, fan keeps running until a further hysteresis drop
// - same hysteresis serves fan switch-off and critical release
// - 0x62 bits 7:5 choose off or minimum duty below start
// - with hold set, switch-off hysteresis has no effect
// - bit 7 output three, bit 5 output one; one holds minimum duty
// - minimum duty is also the start duty above start temperature
`timescale 1ns/1ps
`default_nettype none
module fcso_top (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic reg_wr_en, // register write strobe
  input wire logic reg_rd_en, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wr_data, // write data
  output logic [7:0] reg_rd_data, // read data, held after a read
  input wire logic [7:0] temp_remote_one, // remote one temperature
  input wire logic [7:0] temp_local, // local temperature
  input wire logic [7:0] temp_remote_two, // remote two temperature
  input wire logic [7:0] fan_start_temp_remote_one, // remote one start temperature
  input wire logic [7:0] fan_start_temp_local, // local start temperature
  input wire logic [7:0] fan_start_temp_remote_two, // remote two start temperature
  input wire logic [7:0] min_duty_one, // output one minimum duty
  input wire logic [7:0] min_duty_two, // output two minimum duty
  input wire logic [7:0] min_duty_three, // output three minimum duty
  input wire logic [7:0] max_duty_one, // output one maximum duty
  input wire logic [7:0] max_duty_two, // output two maximum duty
  input wire logic [7:0] max_duty_three, // output three maximum duty
  input wire logic [1:0] fan_chan_sel_one, // channel driving output one
  input wire logic [1:0] fan_chan_sel_two, // channel driving output two
  input wire logic [1:0] fan_chan_sel_three, // channel driving output three
  output logic [7:0] fan_output_one, // output one duty code
  output logic [7:0] fan_output_two, // output two duty code
  output logic [7:0] fan_output_three, // output three duty code
  output logic [2:0] fan_running, // per-output on state
  output logic [2:0] critical_chan_status, // per-channel override state
  output logic critical_temp_signal // override forcing all fans
);

  localparam int unsigned chan_n = fcso_pkg::fcso_chan_n;
  localparam int unsigned out_n = fcso_pkg::fcso_out_n;

  // register storage
  logic [7:0] slope_r1_ff;
  logic [7:0] slope_loc_ff;
  logic [7:0] slope_r2_ff;
  logic [7:0] hold_ff;
  logic [7:0] crit_r1_ff;
  logic [7:0] crit_loc_ff;
  logic [7:0] crit_r2_ff;
  logic [7:0] hyst_a_ff;
  logic [7:0] hyst_b_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  // address decode
  wire logic hit_slope_r1 = reg_addr == fcso_pkg::fcso_off_slope_r1;
  wire logic hit_slope_loc = reg_addr == fcso_pkg::fcso_off_slope_loc;
  wire logic hit_slope_r2 = reg_addr == fcso_pkg::fcso_off_slope_r2;
  wire logic hit_hold = reg_addr == fcso_pkg::fcso_off_hold;
  wire logic hit_crit_r1 = reg_addr == fcso_pkg::fcso_off_crit_r1;
  wire logic hit_crit_loc = reg_addr == fcso_pkg::fcso_off_crit_loc;
  wire logic hit_crit_r2 = reg_addr == fcso_pkg::fcso_off_crit_r2;
  wire logic hit_hyst_a = reg_addr == fcso_pkg::fcso_off_hyst_a;
  wire logic hit_hyst_b = reg_addr == fcso_pkg::fcso_off_hyst_b;

  // reads of unmapped offsets return zero
  assign nxt_rd_data = hit_slope_r1 ? slope_r1_ff :
                       hit_slope_loc ? slope_loc_ff :
                       hit_slope_r2 ? slope_r2_ff :
                       hit_hold ? hold_ff :
                       hit_crit_r1 ? crit_r1_ff :
                       hit_crit_loc ? crit_loc_ff :
                       hit_crit_r2 ? crit_r2_ff :
                       hit_hyst_a ? hyst_a_ff :
                       hit_hyst_b ? hyst_b_ff :
                       8'h00;

  // default slope code 1100, limits 0xa4, hysteresis 4
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slope_r1_ff <= fcso_pkg::fcso_rst_slope;
    end else if (reg_wr_en && hit_slope_r1) begin
      slope_r1_ff <= reg_wr_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slope_loc_ff <= fcso_pkg::fcso_rst_slope;
    end else if (reg_wr_en && hit_slope_loc) begin
      slope_loc_ff <= reg_wr_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slope_r2_ff <= fcso_pkg::fcso_rst_slope;
    end else if (reg_wr_en && hit_slope_r2) begin
      slope_r2_ff <= reg_wr_data;
    end
  end

  // per-output hold bits
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hold_ff <= fcso_pkg::fcso_rst_hold;
    end else if (reg_wr_en && hit_hold) begin
      hold_ff <= reg_wr_data;
    end
  end

  // critical limits, one per channel
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      crit_r1_ff <= fcso_pkg::fcso_rst_crit;
    end else if (reg_wr_en && hit_crit_r1) begin
      crit_r1_ff <= reg_wr_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      crit_loc_ff <= fcso_pkg::fcso_rst_crit;
    end else if (reg_wr_en && hit_crit_loc) begin
      crit_loc_ff <= reg_wr_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      crit_r2_ff <= fcso_pkg::fcso_rst_crit;
    end else if (reg_wr_en && hit_crit_r2) begin
      crit_r2_ff <= reg_wr_data;
    end
  end

  // hysteresis pairs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hyst_a_ff <= fcso_pkg::fcso_rst_hyst_a;
    end else if (reg_wr_en && hit_hyst_a) begin
      hyst_a_ff <= reg_wr_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hyst_b_ff <= fcso_pkg::fcso_rst_hyst_b;
    end else if (reg_wr_en && hit_hyst_b) begin
      hyst_b_ff <= reg_wr_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_ff <= 8'h00;
    end else if (reg_rd_en) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // per-channel arrays: index 0 remote one, 1 local, 2 remote two
  wire logic [7:0] ch_temp [chan_n];
  wire logic [7:0] ch_start [chan_n];
  wire logic [7:0] ch_limit [chan_n];
  wire logic [3:0] ch_hyst [chan_n];
  wire logic [3:0] ch_slope [chan_n];
  wire logic [chan_n-1:0] ch_crit;

  assign ch_temp[0] = temp_remote_one;
  assign ch_temp[1] = temp_local;
  assign ch_temp[2] = temp_remote_two;
  assign ch_start[0] = fan_start_temp_remote_one;
  assign ch_start[1] = fan_start_temp_local;
  assign ch_start[2] = fan_start_temp_remote_two;
  assign ch_limit[0] = crit_r1_ff;
  assign ch_limit[1] = crit_loc_ff;
  assign ch_limit[2] = crit_r2_ff;
  // hysteresis fields
  assign ch_hyst[0] = hyst_a_ff[fcso_pkg::fcso_hyst_hi_lsb +: 4];
  assign ch_hyst[1] = hyst_a_ff[fcso_pkg::fcso_hyst_lo_lsb +: 4];
  assign ch_hyst[2] = hyst_b_ff[fcso_pkg::fcso_hyst_hi_lsb +: 4];
  // one slope code per channel
  assign ch_slope[0] = slope_r1_ff[fcso_pkg::fcso_slope_lsb +: 4];
  assign ch_slope[1] = slope_loc_ff[fcso_pkg::fcso_slope_lsb +: 4];
  assign ch_slope[2] = slope_r2_ff[fcso_pkg::fcso_slope_lsb +: 4];

  genvar gc;
  generate
    for (gc = 0; gc < chan_n; gc++) begin : g_chan
      fcso_crit u_crit (
        .clock(clock),
        .sys_rst(sys_rst),
        .temp(ch_temp[gc]),
        .limit(ch_limit[gc]),
        .hyst(ch_hyst[gc]),
        .active(ch_crit[gc])
      );
    end
  endgenerate

  // per-output arrays
  wire logic [1:0] out_sel [out_n];
  wire logic [7:0] out_min [out_n];
  wire logic [7:0] out_max [out_n];
  wire logic [7:0] out_duty [out_n];
  wire logic [out_n-1:0] out_run;
  logic [7:0] fan_duty_ff [out_n];

  assign out_sel[0] = fan_chan_sel_one;
  assign out_sel[1] = fan_chan_sel_two;
  assign out_sel[2] = fan_chan_sel_three;
  assign out_min[0] = min_duty_one;
  assign out_min[1] = min_duty_two;
  assign out_min[2] = min_duty_three;
  assign out_max[0] = max_duty_one;
  assign out_max[1] = max_duty_two;
  assign out_max[2] = max_duty_three;

  // any channel in override; no mask exists
  wire logic any_crit = |ch_crit;

  genvar go;
  generate
    for (go = 0; go < out_n; go++) begin : g_out
      // selection 3 falls back to remote one
      wire logic [1:0] sel_idx = (out_sel[go] == fcso_pkg::fcso_sel_loc) ? fcso_pkg::fcso_sel_loc :
                                 (out_sel[go] == fcso_pkg::fcso_sel_r2) ? fcso_pkg::fcso_sel_r2 :
                                 fcso_pkg::fcso_sel_r1;
      // hold bit 5 for output one up to bit 7 for output three
      wire logic hold_bit = hold_ff[fcso_pkg::fcso_hold_lsb + go];

      fcso_fan u_fan (
        .clock(clock),
        .sys_rst(sys_rst),
        .temp(ch_temp[sel_idx]),
        .start_temp(ch_start[sel_idx]),
        .hyst(ch_hyst[sel_idx]),
        .slope_code(ch_slope[sel_idx]),
        .min_duty(out_min[go]),
        .max_duty(out_max[go]),
        .hold_min(hold_bit),
        .duty(out_duty[go]),
        .running(out_run[go])
      );

      // override forces full duty over max and automatic settings
      wire logic [7:0] nxt_fan_duty = any_crit ? fcso_pkg::fcso_duty_full : out_duty[go];

      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          fan_duty_ff[go] <= 8'h00;
        end else begin
          fan_duty_ff[go] <= nxt_fan_duty;
        end
      end
    end
  endgenerate

  logic [2:0] run_ff;
  logic [2:0] crit_stat_ff;
  logic crit_sig_ff;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_ff <= 3'h0;
      crit_stat_ff <= 3'h0;
      crit_sig_ff <= 1'b0;
    end else begin
      run_ff <= out_run;
      crit_stat_ff <= ch_crit;
      crit_sig_ff <= any_crit;
    end
  end

  assign reg_rd_data = rd_data_ff;
  assign fan_output_one = fan_duty_ff[0];
  assign fan_output_two = fan_duty_ff[1];
  assign fan_output_three = fan_duty_ff[2];
  assign fan_running = run_ff;
  assign critical_chan_status = crit_stat_ff;
  assign critical_temp_signal = crit_sig_ff;

endmodule // fcso_top
`default_nettype wire
